// *** rtl/trc_top.sv ***
// Purpose: Test access port controller with its reset handling
// Assumes: i_rst_n is power-on reset only; system reset is not an input
// Notes: Test clock is sampled by the system clock, not used as a clock
`timescale 1ns/10ps
`default_nettype none
module trc_top #(
  parameter logic [31:0] ID_VALUE = 32'h0000_0001 // Arbitrary value
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_trst_n,
  output logic o_tdo,
  output logic o_tdo_oe,
  output logic o_bscan_drive,
  output logic o_bscan_highz,
  output logic o_tap_reset,
  output logic [trc_pkg::IR_WIDTH-1:0] o_ir
);
  trc_pin_if pins ();

  trc_pin_sync u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_tck(i_tck),
    .i_tms(i_tms),
    .i_tdi(i_tdi),
    .i_trst_n(i_trst_n),
    .pins(pins)
  );

  trc_pkg::trc_state_t st_q;
  trc_pkg::trc_state_t st_d;
  trc_pkg::trc_state_t st_nx;
  logic [trc_pkg::IR_WIDTH-1:0] ir_q;
  logic [trc_pkg::IR_WIDTH-1:0] ir_sh_q;
  logic [trc_pkg::IDCODE_WIDTH-1:0] dr_q;
  logic tdo_q;
  logic tdo_oe_q;
  logic ext_q;
  logic hz_q;

  // Standard controller diagram
  always_comb begin
    unique case (st_q)
      trc_pkg::ST_RESET:
        st_nx = pins.tms ? trc_pkg::ST_RESET : trc_pkg::ST_IDLE;
      trc_pkg::ST_IDLE:
        st_nx = pins.tms ? trc_pkg::ST_SEL_DR : trc_pkg::ST_IDLE;
      trc_pkg::ST_SEL_DR:
        st_nx = pins.tms ? trc_pkg::ST_SEL_IR : trc_pkg::ST_CAP_DR;
      trc_pkg::ST_CAP_DR:
        st_nx = pins.tms ? trc_pkg::ST_EX1_DR : trc_pkg::ST_SH_DR;
      trc_pkg::ST_SH_DR:
        st_nx = pins.tms ? trc_pkg::ST_EX1_DR : trc_pkg::ST_SH_DR;
      trc_pkg::ST_EX1_DR:
        st_nx = pins.tms ? trc_pkg::ST_UPD_DR : trc_pkg::ST_PAU_DR;
      trc_pkg::ST_PAU_DR:
        st_nx = pins.tms ? trc_pkg::ST_EX2_DR : trc_pkg::ST_PAU_DR;
      trc_pkg::ST_EX2_DR:
        st_nx = pins.tms ? trc_pkg::ST_UPD_DR : trc_pkg::ST_SH_DR;
      trc_pkg::ST_UPD_DR:
        st_nx = pins.tms ? trc_pkg::ST_SEL_DR : trc_pkg::ST_IDLE;
      trc_pkg::ST_SEL_IR:
        st_nx = pins.tms ? trc_pkg::ST_RESET : trc_pkg::ST_CAP_IR;
      trc_pkg::ST_CAP_IR:
        st_nx = pins.tms ? trc_pkg::ST_EX1_IR : trc_pkg::ST_SH_IR;
      trc_pkg::ST_SH_IR:
        st_nx = pins.tms ? trc_pkg::ST_EX1_IR : trc_pkg::ST_SH_IR;
      trc_pkg::ST_EX1_IR:
        st_nx = pins.tms ? trc_pkg::ST_UPD_IR : trc_pkg::ST_PAU_IR;
      trc_pkg::ST_PAU_IR:
        st_nx = pins.tms ? trc_pkg::ST_EX2_IR : trc_pkg::ST_PAU_IR;
      trc_pkg::ST_EX2_IR:
        st_nx = pins.tms ? trc_pkg::ST_UPD_IR : trc_pkg::ST_SH_IR;
      trc_pkg::ST_UPD_IR:
        st_nx = pins.tms ? trc_pkg::ST_SEL_DR : trc_pkg::ST_IDLE;
    endcase
  end

  wire trst_act = ~pins.trst_n;
  wire step = i_ce & pins.tck_rise;
  // Any five TMS-high steps end in reset through the diagram
  assign st_d = trst_act ? trc_pkg::ST_RESET : (step ? st_nx : st_q);

  wire in_reset = (st_q == trc_pkg::ST_RESET);
  wire cap_ir = step & (st_q == trc_pkg::ST_CAP_IR);
  wire sh_ir = step & (st_q == trc_pkg::ST_SH_IR);
  wire upd_ir = step & (st_q == trc_pkg::ST_UPD_IR);
  wire cap_dr = step & (st_q == trc_pkg::ST_CAP_DR);
  wire sh_dr = step & (st_q == trc_pkg::ST_SH_DR);
  wire upd_dr = step & (st_q == trc_pkg::ST_UPD_DR);
  wire is_id = (ir_q == trc_pkg::OP_IDCODE);
  wire shifting = (st_q == trc_pkg::ST_SH_IR) | (st_q == trc_pkg::ST_SH_DR);
  // Instruction current after this edge, so Update-IR takes effect at once
  wire [trc_pkg::IR_WIDTH-1:0] ir_nx = upd_ir ? ir_sh_q : ir_q;
  wire ext_op = (ir_nx == trc_pkg::OP_EXTEST) | (ir_nx == trc_pkg::OP_CLAMP)
    | (ir_nx == trc_pkg::OP_RUNBIST);
  wire hz_op = (ir_nx == trc_pkg::OP_HIGHZ);
  wire tdo_bit = (st_q == trc_pkg::ST_SH_IR) ? ir_sh_q[0] : dr_q[0];

  // Power-on reset lands in the reset state; system reset is absent
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st_q <= trc_pkg::ST_RESET;
    end else if (i_ce) begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ir_q <= trc_pkg::OP_IDCODE;
      ir_sh_q <= trc_pkg::OP_IDCODE;
    end else if (i_ce) begin
      if (in_reset | trst_act) begin
        ir_q <= trc_pkg::OP_IDCODE;
      end else if (upd_ir) begin
        ir_q <= ir_sh_q;
      end
      if (cap_ir) begin
        ir_sh_q <= trc_pkg::IR_CAPTURE;
      end else if (sh_ir) begin
        ir_sh_q <= {pins.tdi, ir_sh_q[trc_pkg::IR_WIDTH-1:1]};
      end
    end
  end

  // Only bypass and device ID are modelled; boundary cells live elsewhere
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      dr_q <= 32'h0000_0000;
    end else if (i_ce) begin
      if (cap_dr) begin
        dr_q <= is_id ? ID_VALUE : 32'h0000_0000;
      end else if (sh_dr) begin
        dr_q <= is_id ? {pins.tdi, dr_q[31:1]} : {31'h0, pins.tdi};
      end
    end
  end

  // Scan controls change on rising test clock edges or while in the reset state or TRST is low, TDO on falling ones
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ext_q <= 1'b0;
      hz_q <= 1'b0;
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (i_ce) begin
      if (in_reset | trst_act) begin
        ext_q <= 1'b0;
        hz_q <= 1'b0;
        tdo_oe_q <= 1'b0;
      end else begin
        if (upd_dr | upd_ir | step) begin
          ext_q <= ext_op;
          hz_q <= hz_op;
        end
        if (pins.tck_fall) begin
          tdo_q <= tdo_bit;
          tdo_oe_q <= shifting;
        end
      end
    end
  end

  assign o_tdo = tdo_q;
  assign o_tdo_oe = tdo_oe_q & ~in_reset;
  assign o_bscan_drive = ext_q;
  assign o_bscan_highz = hz_q;
  assign o_tap_reset = in_reset;
  assign o_ir = ir_q;
endmodule
`default_nettype wire

// *** common/trc_pkg.sv ***
// Purpose: Shared constants for the test port reset control block
// Assumes: Test clock is sampled by the 50 MHz system clock
// Notes: Opcodes and widths of the six-bit instruction register
package trc_pkg;
  localparam int unsigned IR_WIDTH = 6;
  localparam logic [5:0] OP_EXTEST = 6'h00;
  localparam logic [5:0] OP_SAMPLE = 6'h01;
  localparam logic [5:0] OP_IDCODE = 6'h02;
  localparam logic [5:0] OP_CLAMP = 6'h04;
  localparam logic [5:0] OP_RUNBIST = 6'h07;
  localparam logic [5:0] OP_HIGHZ = 6'h08;
  localparam logic [5:0] OP_BYPASS = 6'h3f;
  localparam logic [5:0] IR_CAPTURE = 6'h01;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned IDCODE_WIDTH = 32;

  typedef enum logic [3:0] {
    ST_RESET = 4'b1111,
    ST_IDLE = 4'b1100,
    ST_SEL_DR = 4'b0111,
    ST_CAP_DR = 4'b0110,
    ST_SH_DR = 4'b0010,
    ST_EX1_DR = 4'b0001,
    ST_PAU_DR = 4'b0011,
    ST_EX2_DR = 4'b0000,
    ST_UPD_DR = 4'b0101,
    ST_SEL_IR = 4'b0100,
    ST_CAP_IR = 4'b1110,
    ST_SH_IR = 4'b1010,
    ST_EX1_IR = 4'b1001,
    ST_PAU_IR = 4'b1011,
    ST_EX2_IR = 4'b1000,
    ST_UPD_IR = 4'b1101
  } trc_state_t;
endpackage

// *** common/trc_pin_if.sv ***
// Purpose: Carries synchronised test pin levels and test clock edges
// Assumes: Driven by trc_pin_sync, read by trc_top
// Notes: All signals are on the system clock
`timescale 1ns/10ps
`default_nettype none
interface trc_pin_if;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic trst_n;
  modport src (output tck_rise, output tck_fall, output tms, output tdi,
    output trst_n);
  modport dst (input tck_rise, input tck_fall, input tms, input tdi,
    input trst_n);
endinterface
`default_nettype wire

// *** rtl/trc_pin_sync.sv ***
// Purpose: Three-stage synchronisers for the test pins, edge detection
// Assumes: Pins are asynchronous to i_clk_sys
// Notes: A change counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module trc_pin_sync (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_trst_n,
  trc_pin_if.src pins
);
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] st_q;
  logic [3:0] agree;
  logic [3:0] st_d;

  assign agree = ~(s2_q ^ s3_q);
  assign st_d = (agree & s3_q) | (~agree & st_q);

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      s1_q <= 4'h8;
      s2_q <= 4'h8;
      s3_q <= 4'h8;
      st_q <= 4'h8;
    end else if (i_ce) begin
      s1_q <= {i_trst_n, i_tdi, i_tms, i_tck};
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= st_d;
    end
  end

  assign pins.tck_rise = i_ce & st_d[0] & ~st_q[0];
  assign pins.tck_fall = i_ce & ~st_d[0] & st_q[0];
  assign pins.tms = st_d[1];
  assign pins.tdi = st_d[2];
  assign pins.trst_n = st_q[3];
endmodule
`default_nettype wire

// *** tb/trc_top_props.sv ***
// Purpose: Assertions on test port reset behaviour
// Assumes: i_ce held high
// Notes: Bound into trc_top
`timescale 1ns/10ps
`default_nettype none
module trc_top_props (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_trst_n,
  input wire logic o_tdo,
  input wire logic o_tdo_oe,
  input wire logic o_bscan_drive,
  input wire logic o_bscan_highz,
  input wire logic o_tap_reset,
  input wire logic [trc_pkg::IR_WIDTH-1:0] o_ir
);
  logic tck_q;
  logic [2:0] ones_q;
  wire logic tck_rise = i_tck & ~tck_q;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Counts TCK rises with TMS high, saturating at five
  always_ff @(posedge i_clk_sys) begin
    tck_q <= i_tck;
    if (!i_rst_n || !i_trst_n || (tck_rise && !i_tms)) ones_q <= 3'h0;
    else if (tck_rise && ones_q != 3'h5) ones_q <= ones_q + 3'h1;
  end
  property p_tdo_float; o_tap_reset |-> !o_tdo_oe; endproperty
  a_tdo_float: assert property (p_tdo_float) else $error("tdo on");
  property p_scan_off;
    o_tap_reset [*3] |-> !o_bscan_drive && !o_bscan_highz;
  endproperty
  a_scan_off: assert property (p_scan_off) else $error("scan on");
  property p_ir_id; o_tap_reset [*3] |-> o_ir == trc_pkg::OP_IDCODE;
  endproperty
  a_ir_id: assert property (p_ir_id) else $error("ir not id");
  property p_idle; o_tap_reset [*2] |=> $stable(o_ir); endproperty
  a_idle: assert property (p_idle) else $error("ir moved");
  property p_power_up;
    $rose(i_rst_n) |-> o_tap_reset && o_ir == trc_pkg::OP_IDCODE;
  endproperty
  a_power_up: assert property (p_power_up) else $error("no por");
  property p_trst; $fell(i_trst_n) |-> ##[1:8] o_tap_reset; endproperty
  a_trst: assert property (p_trst) else $error("trst ignored");
  property p_five; ones_q == 3'h5 |-> ##[0:8] o_tap_reset; endproperty
  a_five: assert property (p_five) else $error("five ones");
  property p_leave;
    tck_rise && !i_tms && i_trst_n && o_tap_reset |-> ##[2:8] !o_tap_reset;
  endproperty
  a_leave: assert property (p_leave) else $error("stuck reset");
  c_five: cover property (ones_q == 3'h5);
  c_trst: cover property ($fell(i_trst_n));
  c_highz: cover property (o_bscan_highz);
endmodule
bind trc_top trc_top_props props_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_ce(i_ce), .i_tck(i_tck), .i_tms(i_tms), .i_tdi(i_tdi),
  .i_trst_n(i_trst_n), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe),
  .o_bscan_drive(o_bscan_drive), .o_bscan_highz(o_bscan_highz),
  .o_tap_reset(o_tap_reset), .o_ir(o_ir));
`default_nettype wire

// *** tb/trc_tester.sv ***
// Purpose: Boundary-scan tester model driving the test pins
// Assumes: TCK period is eight system clocks plus the slow count, idle low
// Notes: Tasks are called by the bench
`timescale 1ns/10ps
`default_nettype none
module trc_tester (
  input wire logic i_clk_sys,
  input wire logic i_tdo,
  input wire logic i_tdo_oe,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  output logic o_trst_n
);
  logic [5:0] tdo_bits;
  logic [5:0] oe_bits;
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
    o_trst_n = 1'b1;
  end
  task automatic clk(input logic tms, input logic tdi, input int slow);
    @(posedge i_clk_sys);
    o_tms <= tms;
    o_tdi <= tdi;
    repeat (3 + slow) @(posedge i_clk_sys);
    o_tck <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    o_tck <= 1'b0;
    o_tdi <= ~tdi;
  endtask
  task automatic load_ir(input logic [5:0] op, input int slow);
    clk(1'b0, 1'b0, slow);
    clk(1'b1, 1'b0, slow);
    clk(1'b1, 1'b0, slow);
    clk(1'b0, 1'b0, slow);
    clk(1'b0, 1'b0, slow);
    // TDO still shows the bit of this high phase when TCK falls
    for (int i = 0; i < 6; i++) begin
      clk(i == 5, op[i], slow);
      tdo_bits[i] = i_tdo;
      oe_bits[i] = i_tdo_oe;
    end
    clk(1'b1, 1'b0, slow);
    clk(1'b0, 1'b0, slow);
  endtask
  task automatic pulse_trst();
    @(posedge i_clk_sys);
    o_trst_n <= 1'b0;
    repeat (10) @(posedge i_clk_sys);
    o_trst_n <= 1'b1;
  endtask
  task automatic five_ones();
    repeat (5) clk(1'b1, 1'b0, 0);
  endtask
endmodule
`default_nettype wire

// *** tb/tb_tap_reset_control.sv ***
// Purpose: Self-checking bench for test port reset handling
// Assumes: Tester model owns the test pins
// Notes: Three reset paths rotate over all opcodes
`timescale 1ns/10ps
`default_nettype none
module tb_tap_reset_control;
  logic i_clk_sys = 1'b0;
  logic i_rst_n;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, drive, highz, tap_reset;
  logic [trc_pkg::IR_WIDTH-1:0] ir;
  logic [5:0] op;
  logic [31:0] seed = 32'he5d42988;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [5:0] ops [7] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h07, 6'h08, 6'h3f};
  always #10 i_clk_sys = ~i_clk_sys;
  trc_top dut_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(1'b1),
    .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n), .o_tdo(tdo),
    .o_tdo_oe(tdo_oe), .o_bscan_drive(drive), .o_bscan_highz(highz),
    .o_tap_reset(tap_reset), .o_ir(ir));
  trc_tester tester_u (.i_clk_sys(i_clk_sys), .i_tdo(tdo), .i_tdo_oe(tdo_oe),
    .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));
  wire [9:0] sh_seen = {3'h0, &tester_u.oe_bits, tester_u.tdo_bits};
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [9:0] want(input logic rst, input logic [5:0] o);
    logic drv;
    drv = !rst && (o == 6'h00 || o == 6'h04 || o == 6'h07);
    return {rst, 1'b0, drv, !rst && o == 6'h08, o};
  endfunction
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    i_rst_n = 1'b0;
    repeat (8) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    check({tap_reset, tdo_oe, drive, highz, ir}, want(1'b1, 6'h02));
    for (int k = 0; k < 14; k++) begin
      op = ops[k % 7];
      seed = lfsr(seed);
      tester_u.load_ir(op, int'(seed[1:0]));
      check(sh_seen, {4'h1, trc_pkg::IR_CAPTURE});
      repeat (8) @(posedge i_clk_sys);
      check({tap_reset, tdo_oe, drive, highz, ir}, want(1'b0, op));
      if (k % 3 == 0) tester_u.pulse_trst();
      else if (k % 3 == 1) begin
        for (int j = 0; j < int'(seed[5:2]); j++) begin
          seed = lfsr(seed);
          tester_u.clk(seed[0], seed[1], 0);
        end
        tester_u.five_ones();
      end else begin
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
      end
      repeat (8) @(posedge i_clk_sys);
      check({tap_reset, tdo_oe, drive, highz, ir}, want(1'b1, 6'h02));
    end
    summarize();
  end
endmodule
`default_nettype wire
